//--- rtl/dcr_map.svh
// Constants for the DAC configuration and reset control block.
// Assumes a 125 MHz system clock and an external I2C master on SCL/SDA.
//
// Notes on behaviour
// RULE1 - Power-on copies the stored DAC code into the volatile code register.
// RULE2 - Power-on copies all stored configuration bits into the volatile ones.
// RULE3 - Power-on sets the power-on status flag to one.
// RULE4 - Power-on starts the reset delay; the serial interface works only after it.
// RULE5 - Supply falling forces power-down select to 11 and analog circuits off.
// RULE6 - Supply falling clears the volatile DAC code to zero.
// RULE7 - Supply falling clears reference-select and gain-select bits to zero.
// RULE8 - Reference select picks supply, buffered pin or direct pin; reloaded on events.
// RULE9 - With the supply as reference, the reference pin stays off the ladder.
// RULE10 - With the pin selected, it reaches the ladder buffered or direct.
// RULE11 - Code picks a ladder tap; full scale is element count minus one.
// RULE12 - While powered down, the ladder is cut from its reference.
// RULE13 - Every power-down setting turns the output amplifier off, high impedance.
// RULE14 - Gain of two is allowed only with the reference pin selected.
// RULE15 - With the supply as reference, gain select is ignored; gain is one.
// RULE16 - Gain bit changes only on power-on, brown-out, write or general call reset.
// RULE17 - The DAC code is unsigned binary and with configuration sets the output.
// RULE18 - Data line changes only while the clock is low, except start and stop.
// RULE19 - The device is slave only and never drives the serial clock.
// RULE20 - Incoming data is sampled on clock rise; outgoing data changes on fall.
// RULE21 - A written code loads on the falling edge ending the last byte's ack.
// RULE22 - Power-on or general call reset reloads settings from stored values.
`ifndef DCR_MAP_SVH
`define DCR_MAP_SVH

// ----------------------------------------------------------------------
// Sizes and encodings
// ----------------------------------------------------------------------
`define DCR_CODE_BITS 12
`define DCR_PD_OFF 2'h3
`define DCR_PD_NORMAL 2'h0
`define DCR_REF_BUF 2'h2
`define DCR_REF_DIRECT 2'h3
`define DCR_ADDR_HI 4'hc
`define DCR_GC_ADDR 7'h00
`define DCR_GC_RESET 8'h06
`define DCR_CFG_VREF_MSB 7
`define DCR_CFG_PD_MSB 5
`define DCR_CFG_GAIN 3

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define DCR_CLK_MHZ 125
`define DCR_T_PORD_NS 50000
`define DCR_PORD_CYCLES ((`DCR_T_PORD_NS * `DCR_CLK_MHZ + 999) / 1000)

`endif

//--- rtl/dcr_pkg.sv
// Types shared by the DAC configuration and reset control block.
// Assumes dcr_map.svh is compiled alongside.
package dcr_pkg;
    typedef logic [11:0] dcr_code_t;
    typedef enum logic [1:0] {
        DCR_IDLE = 2'b00,
        DCR_ADDR = 2'b01,
        DCR_WR = 2'b10,
        DCR_RD = 2'b11
    } dcr_link_e;
endpackage

//--- rtl/dcr_top.sv
// Volatile DAC code and configuration with power-event handling and I2C slave.
// Assumes resetn comes from the power-on detector and supply_low from the
// brown-out comparator; SCL is the only link clock and is never driven here.
`timescale 1ns/1ps
`include "dcr_map.svh"

module dcr_top #(
    parameter int PORD_CYCLES = `DCR_PORD_CYCLES
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic supply_low,
    input wire logic [2:0] addr_sel,
    input wire logic [11:0] nv_code,
    input wire logic [1:0] nv_ladder_reference_select,
    input wire logic [1:0] nv_powerdown_select_field,
    input wire logic nv_gain,
    input wire logic scl,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe,
    output logic [11:0] ladder_tap,
    output logic ref_supply_en,
    output logic ref_pin_buf_en,
    output logic ref_pin_direct_en,
    output logic ladder_connect,
    output logic amp_en,
    output logic analog_output_pin_hiz,
    output logic gain2_en,
    output logic [1:0] pulldown_sel,
    output logic por_flag,
    output logic i2c_ready
);

    // ------------------------------------------------------------------
    // Supply events and power-on sequence
    // ------------------------------------------------------------------
    logic bor_s1_q, bor_s2_q, bor_s3_q;
    logic init_q;
    logic por_ev, bor_rise;
    logic [15:0] timer_q;
    logic ready_q;

    always_ff @(posedge clk) begin
        if (!resetn) begin
            bor_s1_q <= 1'b0;
            bor_s2_q <= 1'b0;
            bor_s3_q <= 1'b0;
        end else begin
            bor_s1_q <= supply_low;
            bor_s2_q <= bor_s1_q;
            bor_s3_q <= bor_s2_q;
        end
    end

    // Recovery from brown-out is treated as a fresh power-on.
    assign bor_rise = bor_s2_q && !bor_s3_q;
    assign por_ev = init_q || (!bor_s2_q && bor_s3_q);

    always_ff @(posedge clk) begin
        if (!resetn) begin
            init_q <= 1'b1;
        end else begin
            init_q <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            timer_q <= 16'h0000;
            ready_q <= 1'b0;
        end else if (por_ev) begin
            timer_q <= 16'(PORD_CYCLES); // [RULE4]
            ready_q <= 1'b0;
        end else if (bor_s2_q) begin
            ready_q <= 1'b0;
        end else if (timer_q != 16'h0000) begin
            timer_q <= timer_q - 16'h0001;
        end else begin
            ready_q <= 1'b1; // [RULE4]
        end
    end

    assign i2c_ready = ready_q;

    // ------------------------------------------------------------------
    // Link side: slave on SCL
    // ------------------------------------------------------------------
    dcr_pkg::dcr_link_e st_q;
    logic rdy_s1_q, rdy_s2_q;
    logic [7:0] sh_q;
    logic sda_hi_q;
    logic [3:0] cnt_q;
    logic [1:0] bidx_q;
    logic gc_q;
    logic [7:0] rd_q;
    logic drv_q;
    logic [7:0] cfg_byte_q;
    logic [7:0] hi_byte_q;
    logic [7:0] wcfg_q;
    logic [11:0] wcode_q;
    logic wr_tgl_q;
    logic gc_tgl_q;
    logic mack_q;
    logic [11:0] code_q;
    logic [1:0] vref_q, pd_q;
    logic gain_q, por_q;
    logic start_seen;
    logic addr_hit;

    // The SCL domain has no edges outside frames, so it is held idle by the
    // synchronised ready level rather than by a reset.
    always_ff @(posedge scl) begin
        rdy_s1_q <= ready_q;
        rdy_s2_q <= rdy_s1_q;
    end

    // The acknowledge clock carries no data bit. The received byte is held
    // for the decode at the following fall, and the bit goes to its own flop.
    always_ff @(posedge scl) begin
        if (cnt_q == 4'h8) begin
            mack_q <= sda_i;
        end else begin
            sh_q <= {sh_q[6:0], sda_i}; // [RULE20]
        end
        sda_hi_q <= sda_i;
    end

    // Data never changes while SCL is high, so a drop between rise and fall
    // can only be a start condition.
    assign start_seen = sda_hi_q && !sda_i; // [RULE18]
    assign addr_hit = (sh_q[7:1] == {`DCR_ADDR_HI, addr_sel}) ||
                      (sh_q[7:1] == `DCR_GC_ADDR && !sh_q[0]);

    always_ff @(negedge scl) begin
        if (!rdy_s2_q) begin
            st_q <= dcr_pkg::DCR_IDLE;
            cnt_q <= 4'h0;
            drv_q <= 1'b0;
            // The toggles get a known start here; the clock side ignores
            // their edges until the interface is ready.
            wr_tgl_q <= 1'b0;
            gc_tgl_q <= 1'b0;
        end else if (start_seen) begin
            st_q <= dcr_pkg::DCR_ADDR;
            cnt_q <= 4'h0;
            bidx_q <= 2'h0;
            drv_q <= 1'b0;
        end else if (st_q == dcr_pkg::DCR_IDLE) begin
            drv_q <= 1'b0;
        end else if (cnt_q < 4'h7) begin
            cnt_q <= cnt_q + 4'h1;
            drv_q <= (st_q == dcr_pkg::DCR_RD) && !rd_q[3'(3'h6 - cnt_q[2:0])]; // [RULE20]
        end else if (cnt_q == 4'h7) begin
            cnt_q <= 4'h8;
            case (st_q)
                dcr_pkg::DCR_ADDR: drv_q <= addr_hit;
                dcr_pkg::DCR_WR: drv_q <= 1'b1;
                default: drv_q <= 1'b0;
            endcase
        end else begin
            cnt_q <= 4'h0;
            drv_q <= 1'b0;
            case (st_q)
                dcr_pkg::DCR_ADDR: begin
                    gc_q <= (sh_q[7:1] == `DCR_GC_ADDR);
                    if (!addr_hit) begin
                        st_q <= dcr_pkg::DCR_IDLE;
                    end else if (sh_q[0]) begin
                        st_q <= dcr_pkg::DCR_RD;
                        rd_q <= {por_q, vref_q, pd_q, gain_q, 2'h0};
                        drv_q <= !por_q;
                    end else begin
                        st_q <= dcr_pkg::DCR_WR;
                    end
                end
                dcr_pkg::DCR_WR: begin
                    bidx_q <= bidx_q + 2'h1;
                    if (gc_q) begin
                        if (sh_q == `DCR_GC_RESET) begin
                            gc_tgl_q <= !gc_tgl_q;
                        end
                        st_q <= dcr_pkg::DCR_IDLE;
                    end else if (bidx_q == 2'h0) begin
                        cfg_byte_q <= sh_q;
                    end else if (bidx_q == 2'h1) begin
                        hi_byte_q <= sh_q;
                    end else begin
                        // Commit on the fall that ends the last acknowledge.
                        wcfg_q <= cfg_byte_q;
                        wcode_q <= {hi_byte_q, sh_q[7:4]};
                        wr_tgl_q <= !wr_tgl_q; // [RULE21]
                        st_q <= dcr_pkg::DCR_IDLE;
                    end
                end
                dcr_pkg::DCR_RD: begin
                    if (mack_q) begin
                        st_q <= dcr_pkg::DCR_IDLE;
                    end else begin
                        bidx_q <= bidx_q + 2'h1;
                        rd_q <= (bidx_q == 2'h0) ? code_q[11:4] : {code_q[3:0], 4'h0};
                        drv_q <= (bidx_q == 2'h0) ? !code_q[11] : !code_q[3];
                    end
                end
                default: st_q <= dcr_pkg::DCR_IDLE;
            endcase
        end
    end

    // Open drain: only ever pulls low, and only while the interface is up.
    // SCL is an input only; there is no driver for it here. [RULE19]
    assign sda_o = 1'b0;
    assign sda_oe = drv_q && ready_q;

    // ------------------------------------------------------------------
    // Crossing of write and general call events
    // ------------------------------------------------------------------
    logic wt_s1_q, wt_s2_q, wt_s3_q;
    logic gt_s1_q, gt_s2_q, gt_s3_q;
    logic wr_ev, gc_ev;

    always_ff @(posedge clk) begin
        if (!resetn) begin
            wt_s1_q <= 1'b0;
            wt_s2_q <= 1'b0;
            wt_s3_q <= 1'b0;
            gt_s1_q <= 1'b0;
            gt_s2_q <= 1'b0;
            gt_s3_q <= 1'b0;
        end else begin
            wt_s1_q <= wr_tgl_q;
            wt_s2_q <= wt_s1_q;
            wt_s3_q <= wt_s2_q;
            gt_s1_q <= gc_tgl_q;
            gt_s2_q <= gt_s1_q;
            gt_s3_q <= gt_s2_q;
        end
    end

    // Only edges after the interface came up count; before that the
    // link toggles have no defined start value.
    assign wr_ev = (wt_s2_q ^ wt_s3_q) && ready_q;
    assign gc_ev = (gt_s2_q ^ gt_s3_q) && ready_q;

    // ------------------------------------------------------------------
    // Volatile code and configuration
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!resetn) begin
            code_q <= 12'h000;
            vref_q <= 2'h0;
            pd_q <= `DCR_PD_OFF;
            gain_q <= 1'b0;
        end else if (bor_rise) begin
            pd_q <= `DCR_PD_OFF; // [RULE5]
            code_q <= 12'h000; // [RULE6]
            vref_q <= 2'h0; // [RULE7]
            gain_q <= 1'b0; // [RULE16]
        end else if (por_ev || gc_ev) begin
            code_q <= nv_code; // [RULE1] [RULE22]
            vref_q <= nv_ladder_reference_select; // [RULE2] [RULE8]
            pd_q <= nv_powerdown_select_field;
            gain_q <= nv_gain; // [RULE16]
        end else if (wr_ev) begin
            code_q <= wcode_q;
            vref_q <= wcfg_q[`DCR_CFG_VREF_MSB -: 2];
            pd_q <= wcfg_q[`DCR_CFG_PD_MSB -: 2];
            gain_q <= wcfg_q[`DCR_CFG_GAIN]; // [RULE16]
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            por_q <= 1'b0;
        end else if (por_ev) begin
            por_q <= 1'b1; // [RULE3]
        end else if (wr_ev) begin
            por_q <= 1'b0;
        end
    end

    assign por_flag = por_q;

    // ------------------------------------------------------------------
    // Analog switch and amplifier control
    // ------------------------------------------------------------------
    logic pin_sel, powered;

    assign pin_sel = vref_q[1];
    assign powered = (pd_q == `DCR_PD_NORMAL) && !bor_s2_q;
    // Unsigned code straight to the tap; 4095 leaves one element above. [RULE11] [RULE17]
    assign ladder_tap = code_q;
    assign ref_supply_en = !pin_sel && powered; // [RULE8]
    assign ref_pin_buf_en = (vref_q == `DCR_REF_BUF) && powered; // [RULE10]
    assign ref_pin_direct_en = (vref_q == `DCR_REF_DIRECT) && powered; // [RULE9]
    assign ladder_connect = powered; // [RULE12]
    assign amp_en = powered;
    assign analog_output_pin_hiz = !powered; // [RULE13]
    assign gain2_en = gain_q && pin_sel; // [RULE14] [RULE15]
    assign pulldown_sel = pd_q;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    logic [3:0] wait_q;

    always_ff @(posedge clk) begin
        if (!resetn || por_ev) begin
            wait_q <= 4'h0;
        end else if (wait_q != 4'hf) begin
            wait_q <= wait_q + 4'h1;
        end
    end

    a_por_code_load: assert property (@(posedge clk) disable iff (!resetn) // [RULE1]
        (por_ev && !bor_rise && !gc_ev) |=> (code_q == $past(nv_code)))
        else $error("code not loaded from storage at power-on");

    a_por_cfg_load: assert property (@(posedge clk) disable iff (!resetn) // [RULE2]
        (por_ev && !bor_rise) |=> (vref_q == $past(nv_ladder_reference_select)
        && pd_q == $past(nv_powerdown_select_field) && gain_q == $past(nv_gain)))
        else $error("configuration not loaded at power-on");

    a_por_flag_set: assert property (@(posedge clk) disable iff (!resetn) // [RULE3]
        por_ev |=> por_flag)
        else $error("power-on flag not set");

    a_ready_delay: assert property (@(posedge clk) disable iff (!resetn) // [RULE4]
        (wait_q < 4'hf && PORD_CYCLES > 14) |-> !i2c_ready)
        else $error("interface ready before reset delay");

    a_bor_pd_off: assert property (@(posedge clk) disable iff (!resetn) // [RULE5]
        bor_rise |=> (pulldown_sel == `DCR_PD_OFF) && !amp_en && !ladder_connect)
        else $error("brown-out did not power down");

    a_bor_code_zero: assert property (@(posedge clk) disable iff (!resetn) // [RULE6]
        bor_rise |=> (ladder_tap == 12'h000))
        else $error("brown-out did not clear code");

    a_bor_cfg_zero: assert property (@(posedge clk) disable iff (!resetn) // [RULE7]
        bor_rise |=> (vref_q == 2'h0) && !gain_q)
        else $error("brown-out did not clear reference and gain");

    a_supply_isolates: assert property (@(posedge clk) disable iff (!resetn) // [RULE9]
        !vref_q[1] |-> !ref_pin_buf_en && !ref_pin_direct_en)
        else $error("reference pin on ladder with supply selected");

    a_pd_amp_hiz: assert property (@(posedge clk) disable iff (!resetn) // [RULE13]
        (pulldown_sel != `DCR_PD_NORMAL) |-> !amp_en && analog_output_pin_hiz
        && !ladder_connect)
        else $error("amplifier or ladder live while powered down");

    a_gain_supply: assert property (@(posedge clk) disable iff (!resetn) // [RULE15]
        ref_supply_en |-> !gain2_en)
        else $error("gain two with supply reference");

    a_gain_cause: assert property (@(posedge clk) disable iff (!resetn) // [RULE16]
        $changed(gain_q) |-> $past(por_ev || bor_rise || wr_ev || gc_ev))
        else $error("gain bit changed without a cause");

    a_pin_route: assert property (@(posedge clk) disable iff (!resetn) // [RULE10]
        (vref_q[1] && powered) |-> (ref_pin_buf_en != ref_pin_direct_en) && !ref_supply_en)
        else $error("reference pin not routed to the ladder");

    a_gain_pin_only: assert property (@(posedge clk) disable iff (!resetn) // [RULE14]
        gain2_en |-> vref_q[1] && !ref_supply_en)
        else $error("gain two without the reference pin");

    a_write_commit: assert property (@(posedge clk) disable iff (!resetn) // [RULE21]
        (wr_ev && !por_ev && !bor_rise && !gc_ev) |=> (code_q == $past(wcode_q))
        && (gain_q == $past(wcfg_q[`DCR_CFG_GAIN])))
        else $error("written code not loaded");

    a_gencall_load: assert property (@(posedge clk) disable iff (!resetn) // [RULE22]
        (gc_ev && !bor_rise) |=> (code_q == $past(nv_code)) && (gain_q == $past(nv_gain)))
        else $error("general call did not reload storage");

    a_sda_pull_only: assert property (@(posedge clk) disable iff (!resetn) // [RULE19]
        sda_oe |-> !sda_o && i2c_ready)
        else $error("data line driven high or while not ready");

endmodule

//--- verification/dcr_i2c_master.sv
// I2C master model that drives the link of the DAC control block.
// Assumes the bench resolves SDA with a pull-up; SCL idles high between frames.
`timescale 1ns/1ps
module dcr_i2c_master (
    output logic scl,
    output logic sda_low,
    input wire logic sda
);
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    task automatic bit_out(input logic b);
        #3.75 sda_low = ~b;
        #3.75 scl = 1'b1;
        #7.5 scl = 1'b0;
    endtask
    task automatic frame_start();
        // The slave sees a start only between an SCL rise and fall, so a
        // frame opens by taking SCL low with the data line released.
        scl = 1'b0;
        #3.75 sda_low = 1'b0;
        #3.75 scl = 1'b1;
        #7.5 sda_low = 1'b1;
        #7.5 scl = 1'b0;
    endtask
    task automatic stop();
        #3.75 sda_low = 1'b1;
        #3.75 scl = 1'b1;
        #7.5 sda_low = 1'b0;
        #7.5;
    endtask
    task automatic put(input logic [7:0] d, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            bit_out(d[i]);
        end
        sda_low = 1'b0;
        #7.5 scl = 1'b1;
        #3.75 ack = sda;
        #3.75 scl = 1'b0;
    endtask
    task automatic get(input logic nack, output logic [7:0] d);
        sda_low = 1'b0;
        for (int i = 7; i >= 0; i--) begin
            #7.5 scl = 1'b1;
            #3.75 d[i] = sda;
            #3.75 scl = 1'b0;
        end
        bit_out(nack);
    endtask
endmodule

//--- verification/dcr_top_bench.sv
// Self-checking bench for the DAC configuration and reset control block.
// Assumes dcr_i2c_master as the link partner and a pull-up on SDA.
`timescale 1ns/1ps
module dcr_top_bench;
    localparam int PORD = 40;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic supply_low = 1'b0;
    logic [2:0] addr_sel = 3'h5;
    logic [11:0] nv_code = 12'h9a5;
    logic [1:0] nv_vref = 2'h2;
    logic [1:0] nv_pd = 2'h0;
    logic nv_gain = 1'b1;
    logic scl, sda_low, sda_o, sda_oe, ref_sup, ref_buf, ref_dir, lad_con, amp_en, hiz;
    logic gain2, por_flag, i2c_ready, ack;
    logic [11:0] tap;
    logic [1:0] pd_sel;
    logic [7:0] rd;
    wire sda = ~((sda_oe & ~sda_o) | sda_low);
    int err_count = 0;
    int checked = 0;
    int cyc = 0;
    int rel = 0;
    always #4 clk = ~clk;
    always @(posedge clk) cyc <= cyc + 1;
    dcr_top #(.PORD_CYCLES(PORD)) dut_u (.clk(clk), .resetn(resetn), .supply_low(supply_low),
        .addr_sel(addr_sel), .nv_code(nv_code), .nv_ladder_reference_select(nv_vref),
        .nv_powerdown_select_field(nv_pd), .nv_gain(nv_gain), .scl(scl), .sda_i(sda),
        .sda_o(sda_o), .sda_oe(sda_oe), .ladder_tap(tap), .ref_supply_en(ref_sup),
        .ref_pin_buf_en(ref_buf), .ref_pin_direct_en(ref_dir), .ladder_connect(lad_con),
        .amp_en(amp_en), .analog_output_pin_hiz(hiz), .gain2_en(gain2), .pulldown_sel(pd_sel),
        .por_flag(por_flag), .i2c_ready(i2c_ready));
    dcr_i2c_master m_u (.scl(scl), .sda_low(sda_low), .sda(sda));
    task automatic end_of_test();
        $display("checked %0d errors %0d", checked, err_count);
        if (err_count == 0 && checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
        checked++;
        if (seen !== exp) begin
            err_count++;
            $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic clks(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic cfg_chk(input logic [1:0] v, input logic [1:0] p, input logic g,
                           input logic [11:0] c);
        logic [2:0] r_exp;
        r_exp = v[1] ? {1'b0, ~v[0], v[0]} : 3'h4;
        chk(tap, c);
        chk(12'(pd_sel), 12'(p));
        chk(12'({lad_con, amp_en, hiz}), (p == 2'h0) ? 12'h6 : 12'h1);
        if (p == 2'h0) begin
            chk(12'({ref_sup, ref_buf, ref_dir}), 12'(r_exp));
            chk(12'(gain2), 12'(g & v[1]));
        end
    endtask
    // Address-only frame; it also gives SCL edges so the ready flag reaches the link side.
    task automatic ping(input logic [7:0] adr, input logic a_exp);
        m_u.frame_start();
        m_u.put(adr, ack);
        m_u.stop();
        chk(12'(ack), 12'(a_exp));
    endtask
    task automatic wr(input logic [7:0] adr, input logic [7:0] cfg, input logic [11:0] c,
                      input logic a_exp);
        m_u.frame_start();
        m_u.put(adr, ack);
        chk(12'(ack), 12'(a_exp));
        m_u.put(cfg, ack);
        m_u.put(c[11:4], ack);
        m_u.put({c[3:0], 4'h0}, ack);
        m_u.stop();
        clks(6);
    endtask
    task automatic wrw(input logic [1:0] v, input logic [1:0] p, input logic g,
                       input logic [11:0] c);
        wr({4'hc, addr_sel, 1'b0}, {v, p, g, 3'h0}, c, 1'b0);
        cfg_chk(v, p, g, c);
    endtask
    // ----------------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------------
    task automatic t_power_on();
        clks(3);
        chk(12'(por_flag), 12'h1);
        cfg_chk(nv_vref, nv_pd, nv_gain, nv_code);
        ping({4'hc, addr_sel, 1'b0}, 1'b1);
        while (cyc < rel + PORD) @(negedge clk);
        chk(12'(i2c_ready), 12'h0);
        clks(4);
        chk(12'(i2c_ready), 12'h1);
        ping(8'hfe, 1'b1);
    endtask
    task automatic t_refs();
        logic [11:0] codes [4] = '{12'hfff, 12'h000, 12'h800, 12'h5a3};
        for (int v = 0; v < 4; v++) begin
            wrw(2'(v), 2'h0, 1'b1, codes[v]);
        end
        for (int p = 1; p < 4; p++) begin
            wrw(2'h2, 2'(p), 1'b0, 12'h3c0 + 12'(p));
        end
    endtask
    task automatic t_read();
        m_u.frame_start();
        m_u.put({4'hc, addr_sel, 1'b1}, ack);
        m_u.get(1'b0, rd);
        chk(12'(rd), 12'h58);
        m_u.get(1'b0, rd);
        chk(12'(rd), 12'h3c);
        m_u.get(1'b1, rd);
        chk(12'(rd), 12'h30);
        m_u.stop();
    endtask
    task automatic t_refused();
        wr({4'hc, addr_sel ^ 3'h1, 1'b0}, 8'hc8, 12'h111, 1'b1);
        m_u.frame_start();
        m_u.put({4'hc, addr_sel, 1'b0}, ack);
        m_u.put(8'hc8, ack);
        m_u.put(8'h11, ack);
        m_u.stop();
        clks(6);
        cfg_chk(2'h2, 2'h3, 1'b0, 12'h3c3);
    endtask
    task automatic t_gencall();
        m_u.frame_start();
        m_u.put(8'h00, ack);
        m_u.put(8'h06, ack);
        m_u.stop();
        chk(12'(ack), 12'h0);
        clks(6);
        cfg_chk(nv_vref, nv_pd, nv_gain, nv_code);
    endtask
    task automatic t_brownout();
        wrw(2'h3, 2'h0, 1'b1, 12'hfff);
        supply_low = 1'b1;
        clks(5);
        chk(tap, 12'h000);
        chk(12'({pd_sel, amp_en, hiz, lad_con}), 12'h1a);
        chk(12'({ref_buf, ref_dir, gain2, i2c_ready}), 12'h0);
        nv_code = 12'h123;
        nv_vref = 2'h3;
        supply_low = 1'b0;
        for (int i = 0; i < 200 && i2c_ready !== 1'b1; i++) @(negedge clk);
        chk(12'({i2c_ready, por_flag}), 12'h3);
        cfg_chk(2'h3, 2'h0, 1'b1, 12'h123);
        ping(8'hfe, 1'b1);
        ping({4'hc, addr_sel, 1'b0}, 1'b0);
    endtask
    initial begin
        #100000;
        err_count++;
        $display("ERROR %0t: watchdog expired", $time);
        end_of_test();
    end
    initial begin
        clks(10);
        resetn = 1'b1;
        rel = cyc;
        t_power_on();
        t_refs();
        t_read();
        t_refused();
        t_gencall();
        t_brownout();
        end_of_test();
    end
endmodule
